/* rtl/pbisf_status_regs.sv */
`timescale 1ns/1ps
// ==========================================================================
// Summary of operation
// - A PCI parity error sets status bit 8, which software clears by writing one to bit 8 of the clear register.
// - Driving the system error pin sets status bit 7.
// - A master abort on an own PCI master access sets status bit 6.
// - A target abort received on an own PCI master access sets status bit 5.
// - Ending a transfer as target with target abort sets status bit 4.
// - Delayed read data unclaimed for 2^15 clocks is dropped and sets bit 3.
// - Retry limit expiry abandons the retried access and sets bit 2.
// - A bus error on an internal bus read as master sets status bit 1.
// - A bus error on an internal bus write as master sets status bit 0.
// - A status bit requests the interrupt only while its enable bit is one.
// ==========================================================================
module pbisf_status_regs #(
   parameter int unsigned DISCARD_CYCLES = pbisf_pkg::DISCARD_CYCLES
) (
   // Clock and reset
   input  wire logic                  hclk,
   input  wire logic                  hresetn,
   // AHB-Lite slave
   input  wire logic                  hsel,
   input  wire logic [31:0]           haddr,
   input  wire logic [1:0]            htrans,
   input  wire logic                  hwrite,
   input  wire logic [2:0]            hsize,
   input  wire logic [31:0]           hwdata,
   input  wire logic                  hready,
   output logic                       hreadyout,
   output logic                       hresp,
   output logic      [31:0]           hrdata,
   // Bridge engine events
   input  wire pbisf_pkg::pbisf_evt_t evt,
   input  wire logic                  system_error_request,
   // Delayed read data hold
   input  wire logic                  dr_data_loaded,
   input  wire logic                  dr_data_claimed,
   output logic                       delayed_read_data_dropped,
   // Retried master access
   input  wire logic                  rty_access_start,
   input  wire logic                  rty_retry_seen,
   input  wire logic                  rty_access_done,
   output logic                       retry_limit_expired,
   // System error pin, open drain
   output logic                       system_error_out_n_o,
   output logic                       system_error_out_n_oe,
   // Interrupt
   output logic                       irq
);

   // =======================================================================
   // Declarations
   pbisf_pkg::pbisf_aphase_t    aph_q;
   pbisf_pkg::pbisf_aphase_t    aph_d;
   pbisf_pkg::pbisf_rty_state_t rty_state_q;
   pbisf_pkg::pbisf_rty_state_t rty_state_d;

   logic [8:0]  flags;
   logic [8:0]  flag_set;
   logic [8:0]  flag_clr;
   logic [8:0]  enable_q;
   logic [8:0]  enable_d;
   logic [31:0] rty_lim_q;
   logic [31:0] rty_lim_d;
   logic [31:0] rty_cnt_q;
   logic [31:0] rty_cnt_d;
   logic [31:0] rdata_d;
   logic [31:0] live_word;
   logic        serr_drive_q;
   logic        rty_expire_d;
   logic        rty_expire_q;
   logic        rty_limit_on;
   logic        rty_at_limit;
   logic        dr_active;
   logic        dr_expire;
   logic        irq_d;
   logic        aph_valid;
   logic        wr_enable;
   logic        wr_clear;
   logic        wr_rty_lim;

   // =======================================================================
   // Bus answer, zero wait, always OKAY
   assign hreadyout = 1'b1;
   assign hresp     = pbisf_pkg::HRESP_OKAY;

   // Address phase capture, word transfers only
   assign aph_valid = hsel && hready && (htrans == pbisf_pkg::HTRANS_NONSEQ)
                      && (hsize == pbisf_pkg::HSIZE_WORD);
   assign aph_d.wr  = aph_valid && hwrite;
   assign aph_d.rd  = aph_valid && !hwrite;
   assign aph_d.ofs = haddr[7:0];

   // Address phase register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         aph_q <= '0;
      end else begin
         aph_q <= aph_d;
      end
   end

   // =======================================================================
   // Write decode in the data phase
   assign wr_enable  = aph_q.wr && pbisf_pkg::ofs_hit(aph_q.ofs, pbisf_pkg::OFS_ENABLE);
   assign wr_clear   = aph_q.wr && pbisf_pkg::ofs_hit(aph_q.ofs, pbisf_pkg::OFS_CLEAR);
   assign wr_rty_lim = aph_q.wr && pbisf_pkg::ofs_hit(aph_q.ofs, pbisf_pkg::OFS_RTY_LIM);

   // Next values of software registers
   assign enable_d  = wr_enable  ? hwdata[8:0] : enable_q;
   assign rty_lim_d = wr_rty_lim ? hwdata      : rty_lim_q;
   assign flag_clr  = wr_clear   ? hwdata[8:0] : 9'h000;

   // Enable and retry limit storage
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         enable_q  <= pbisf_pkg::ENABLE_RESET;
         rty_lim_q <= pbisf_pkg::RTY_RESET;
      end else begin
         enable_q  <= enable_d;
         rty_lim_q <= rty_lim_d;
      end
   end

   // =======================================================================
   // Read data selection, registered into the data phase
   assign live_word = {29'h0000_0000,
                       (rty_state_q == pbisf_pkg::RT_ACTIVE),
                       dr_active,
                       serr_drive_q};

   // Status and state readback
   always_comb begin
      rdata_d = pbisf_pkg::WORD_ZERO;
      if (aph_d.rd) begin
         case (aph_d.ofs)
            pbisf_pkg::OFS_STATUS:  rdata_d = {23'h000000, flags};
            pbisf_pkg::OFS_ENABLE:  rdata_d = {23'h000000, enable_q};
            pbisf_pkg::OFS_RTY_LIM: rdata_d = rty_lim_q;
            pbisf_pkg::OFS_RTY_CNT: rdata_d = rty_cnt_q;
            pbisf_pkg::OFS_LIVE:    rdata_d = live_word;
            default:                rdata_d = pbisf_pkg::WORD_ZERO;
         endcase
      end
   end

   // Read data register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= pbisf_pkg::WORD_ZERO;
      end else begin
         hrdata <= rdata_d;
      end
   end

   // =======================================================================
   // System error pin, driven low while requested
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         serr_drive_q <= 1'b0;
      end else begin
         serr_drive_q <= system_error_request;
      end
   end

   assign system_error_out_n_o  = 1'b0;
   assign system_error_out_n_oe = serr_drive_q;

   // =======================================================================
   // Delayed read hold timer
   pbisf_hold_timer #(
      .CW    (pbisf_pkg::TMR_W),
      .LIMIT (DISCARD_CYCLES)
   ) u_hold_timer (
      .clk    (hclk),
      .rst_n  (hresetn),
      .start  (dr_data_loaded),
      .claim  (dr_data_claimed),
      .active (dr_active),
      .expire (dr_expire)
   );

   assign delayed_read_data_dropped = dr_expire;

   // =======================================================================
   // Retry limit counter, zero limit disables
   assign rty_limit_on = (rty_lim_q != pbisf_pkg::RTY_RESET);
   assign rty_at_limit = (rty_cnt_q + 32'h0000_0001) >= rty_lim_q;
   assign rty_expire_d = (rty_state_q == pbisf_pkg::RT_ACTIVE) && rty_retry_seen
                         && rty_limit_on && rty_at_limit;

   // Retry state and count selection
   always_comb begin
      rty_state_d = rty_state_q;
      rty_cnt_d   = rty_cnt_q;
      case (rty_state_q)
         pbisf_pkg::RT_IDLE: begin
            if (rty_access_start) begin
               rty_state_d = pbisf_pkg::RT_ACTIVE;
               rty_cnt_d   = pbisf_pkg::RTY_RESET;
            end
         end
         pbisf_pkg::RT_ACTIVE: begin
            if (rty_expire_d || rty_access_done) begin
               rty_state_d = pbisf_pkg::RT_IDLE;
            end else if (rty_retry_seen) begin
               rty_cnt_d = rty_cnt_q + 32'h0000_0001;
            end
         end
         default: begin
            rty_state_d = pbisf_pkg::RT_IDLE;
            rty_cnt_d   = pbisf_pkg::RTY_RESET;
         end
      endcase
   end

   // Retry state register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rty_state_q  <= pbisf_pkg::RT_IDLE;
         rty_cnt_q    <= pbisf_pkg::RTY_RESET;
         rty_expire_q <= 1'b0;
      end else begin
         rty_state_q  <= rty_state_d;
         rty_cnt_q    <= rty_cnt_d;
         rty_expire_q <= rty_expire_d;
      end
   end

   assign retry_limit_expired = rty_expire_q;

   // =======================================================================
   // Flag set sources
   assign flag_set[pbisf_pkg::BIT_PARITY]      = evt.parity_error_seen;
   assign flag_set[pbisf_pkg::BIT_SERR_DRIVEN] = serr_drive_q;
   assign flag_set[pbisf_pkg::BIT_MA_RECEIVED] = evt.master_abort_received;
   assign flag_set[pbisf_pkg::BIT_TA_RECEIVED] = evt.target_abort_received;
   assign flag_set[pbisf_pkg::BIT_TA_ISSUED]   = evt.target_abort_issued;
   assign flag_set[pbisf_pkg::BIT_DR_DROPPED]  = dr_expire;
   assign flag_set[pbisf_pkg::BIT_RTY_EXPIRED] = rty_expire_q;
   assign flag_set[pbisf_pkg::BIT_RD_BUS_ERR]  = evt.local_read_bus_error;
   assign flag_set[pbisf_pkg::BIT_WR_BUS_ERR]  = evt.local_write_bus_error;

   // Sticky status flags
   pbisf_flag_bank #(
      .W (pbisf_pkg::FLAG_W)
   ) u_flags (
      .clk   (hclk),
      .rst_n (hresetn),
      .set   (flag_set),
      .clr   (flag_clr),
      .q     (flags)
   );

   // =======================================================================
   // Interrupt, enabled flags only
   assign irq_d = |(flags & enable_q);

   // Interrupt register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= irq_d;
      end
   end

endmodule : pbisf_status_regs

/* rtl/pbisf_pkg.sv */
// ==========================================================================
// Shared constants and types
package pbisf_pkg;

   // =======================================================================
   // Widths
   localparam int unsigned FLAG_W  = 9;
   localparam int unsigned OFS_W   = 8;
   localparam int unsigned DATA_W  = 32;
   localparam int unsigned TMR_W   = 16;

   // =======================================================================
   // Register byte offsets
   localparam logic [7:0] OFS_STATUS   = 8'h00;
   localparam logic [7:0] OFS_ENABLE   = 8'h04;
   localparam logic [7:0] OFS_CLEAR    = 8'h08;
   localparam logic [7:0] OFS_RTY_LIM  = 8'h0C;
   localparam logic [7:0] OFS_RTY_CNT  = 8'h10;
   localparam logic [7:0] OFS_LIVE     = 8'h14;

   // =======================================================================
   // Status bit positions
   localparam int unsigned BIT_WR_BUS_ERR  = 0;
   localparam int unsigned BIT_RD_BUS_ERR  = 1;
   localparam int unsigned BIT_RTY_EXPIRED = 2;
   localparam int unsigned BIT_DR_DROPPED  = 3;
   localparam int unsigned BIT_TA_ISSUED   = 4;
   localparam int unsigned BIT_TA_RECEIVED = 5;
   localparam int unsigned BIT_MA_RECEIVED = 6;
   localparam int unsigned BIT_SERR_DRIVEN = 7;
   localparam int unsigned BIT_PARITY      = 8;

   // Live state bit positions
   localparam int unsigned LIVE_SERR       = 0;
   localparam int unsigned LIVE_DR_HELD    = 1;
   localparam int unsigned LIVE_RTY_ACTIVE = 2;

   // =======================================================================
   // Reset values
   localparam logic [8:0]  FLAG_RESET   = 9'h000;
   localparam logic [8:0]  ENABLE_RESET = 9'h000;
   localparam logic [31:0] RTY_RESET    = 32'h0000_0000;
   localparam logic [31:0] WORD_ZERO    = 32'h0000_0000;

   // =======================================================================
   // Bus codes
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD    = 3'h2;
   localparam logic       HRESP_OKAY    = 1'b0;

   // =======================================================================
   // Delayed read hold time, in controller clocks
   localparam int unsigned DISCARD_EXP    = 15;
   localparam int unsigned DISCARD_CLOCKS = 2 ** DISCARD_EXP;
   localparam int unsigned DISCARD_CYCLES = DISCARD_CLOCKS * 1;

   // =======================================================================
   // Types
   typedef enum logic [0:0] {
      RT_IDLE   = 1'b0,
      RT_ACTIVE = 1'b1
   } pbisf_rty_state_t;

   typedef struct packed {
      logic parity_error_seen;
      logic master_abort_received;
      logic target_abort_received;
      logic target_abort_issued;
      logic local_read_bus_error;
      logic local_write_bus_error;
   } pbisf_evt_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] ofs;
   } pbisf_aphase_t;

   // Offset compare
   function automatic logic ofs_hit(input logic [7:0] ofs, input logic [7:0] target);
      ofs_hit = (ofs == target);
   endfunction : ofs_hit

endpackage : pbisf_pkg

/* rtl/pbisf_flag_bank.sv */
`timescale 1ns/1ps
// ==========================================================================
// Sticky flags, set beats clear
module pbisf_flag_bank #(
   parameter int unsigned W = 9
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // Set and clear strobes
   input  wire logic [W-1:0] set,
   input  wire logic [W-1:0] clr,
   // Flag state
   output logic      [W-1:0] q
);

   logic [W-1:0] q_d;

   // Set wins over clear in the same cycle
   assign q_d = (q & ~clr) | set;

   // Flag storage
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= q_d;
      end
   end

endmodule : pbisf_flag_bank

/* rtl/pbisf_hold_timer.sv */
`timescale 1ns/1ps
// ==========================================================================
// Hold timer for prefetched delayed read data
module pbisf_hold_timer #(
   parameter int unsigned CW    = 16,
   parameter int unsigned LIMIT = 32768
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // Data held and claimed strobes
   input  wire logic start,
   input  wire logic claim,
   // Timer state
   output logic      active,
   output logic      expire
);

   localparam logic [CW-1:0] LAST = CW'(LIMIT - 1);

   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;
   logic          active_d;
   logic          at_last;
   logic          expire_d;

   // Next state selection
   assign at_last  = active && (cnt_q == LAST);
   assign expire_d = at_last && !start && !claim;
   assign active_d = start || (active && !claim && !at_last);
   assign cnt_d    = start ? '0 : (active ? cnt_q + 1'b1 : cnt_q);

   // Counter and expiry pulse
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q  <= '0;
         active <= 1'b0;
         expire <= 1'b0;
      end else begin
         cnt_q  <= cnt_d;
         active <= active_d;
         expire <= expire_d;
      end
   end

endmodule : pbisf_hold_timer

/* tb/pbisf_status_asserts.sv */
`timescale 1ns/1ps
// ==========================================================================
// Port checks for the bridge status block
module pbisf_status_asserts #(
   parameter int unsigned DISCARD_CYCLES = 8
) (
   // Clock and reset
   input wire logic                  hclk,
   input wire logic                  hresetn,
   // Bus address phase
   input wire logic                  hsel,
   input wire logic [1:0]            htrans,
   input wire logic                  hwrite,
   input wire logic                  hready,
   // Engine side
   input wire pbisf_pkg::pbisf_evt_t evt,
   input wire logic                  system_error_request,
   input wire logic                  dr_data_loaded,
   input wire logic                  dr_data_claimed,
   input wire logic                  delayed_read_data_dropped,
   input wire logic                  rty_retry_seen,
   input wire logic                  retry_limit_expired,
   // Pin and interrupt
   input wire logic                  system_error_out_n_o,
   input wire logic                  system_error_out_n_oe,
   input wire logic                  irq
);
   logic        wr_ap;
   logic        cause;
   logic [15:0] age_q;
   logic [15:0] age_d;

   // Write taken, and anything that may raise a flag or an enable
   assign wr_ap = hsel && hready && htrans == pbisf_pkg::HTRANS_NONSEQ && hwrite;
   assign cause = wr_ap || (|evt) || system_error_out_n_oe || delayed_read_data_dropped
                  || retry_limit_expired;
   // Age of held read data, saturated when nothing is held
   assign age_d = dr_data_loaded ? 16'h0000 :
                  (dr_data_claimed || delayed_read_data_dropped || age_q == 16'hFFFF) ?
                  16'hFFFF : age_q + 16'h0001;

   // Age counter
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         age_q <= 16'hFFFF;
      end else begin
         age_q <= age_d;
      end
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   pin_drive_a: assert property (system_error_request |=> system_error_out_n_oe)
      else $error("pin not driven after request");
   pin_release_a: assert property (!system_error_request |=> !system_error_out_n_oe)
      else $error("pin driven without request");
   pin_low_a: assert property (system_error_out_n_oe |-> !system_error_out_n_o)
      else $error("pin driven high");
   irq_cause_a: assert property ($rose(irq) |-> $past(cause, 2) || $past(cause, 3))
      else $error("interrupt rose without cause");
   irq_hold_a: assert property ($fell(irq) |-> $past(wr_ap, 2) || $past(wr_ap, 3))
      else $error("interrupt fell without a write");
   drop_time_a: assert property (delayed_read_data_dropped |->
      32'(age_q) + 32'd2 >= DISCARD_CYCLES && 32'(age_q) <= DISCARD_CYCLES + 32'd1)
      else $error("held data dropped at wrong time");
   drop_pulse_a: assert property (delayed_read_data_dropped |=> !delayed_read_data_dropped)
      else $error("drop strobe longer than one cycle");
   rty_cause_a: assert property (retry_limit_expired |-> $past(rty_retry_seen))
      else $error("retry expiry without a retry");
endmodule : pbisf_status_asserts

bind pbisf_status_regs pbisf_status_asserts #(.DISCARD_CYCLES(DISCARD_CYCLES))
   u_pbisf_status_asserts (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .evt,
   .system_error_request, .dr_data_loaded, .dr_data_claimed, .delayed_read_data_dropped,
   .rty_retry_seen, .retry_limit_expired, .system_error_out_n_o, .system_error_out_n_oe, .irq);

/* tb/pbisf_engine_model.sv */
`timescale 1ns/1ps
// ==========================================================================
// Bridge engines: raise event strobes on command
module pbisf_engine_model (
   // Clock
   input wire logic              clk,
   // Strobes toward the status block
   output pbisf_pkg::pbisf_evt_t evt,
   output logic                  serr_req,
   output logic                  loaded,
   output logic                  claimed,
   output logic                  rty_start,
   output logic                  rty_retry,
   output logic                  rty_done
);
   logic [10:0] strobe_q = 11'h000;
   logic        serr_q   = 1'b0;

   // Strobe fan-out
   assign evt       = pbisf_pkg::pbisf_evt_t'(strobe_q[5:0]);
   assign loaded    = strobe_q[6];
   assign claimed   = strobe_q[7];
   assign rty_start = strobe_q[8];
   assign rty_retry = strobe_q[9];
   assign rty_done  = strobe_q[10];
   assign serr_req  = serr_q;

   // One cycle strobe of one kind
   task automatic pulse(input int unsigned kind);
      @(posedge clk);
      strobe_q <= 11'h001 << kind;
      @(posedge clk);
      strobe_q <= 11'h000;
   endtask : pulse

   // System error request held for n cycles
   task automatic serr(input int unsigned n);
      @(posedge clk);
      serr_q <= 1'b1;
      repeat (n) @(posedge clk);
      serr_q <= 1'b0;
   endtask : serr
endmodule : pbisf_engine_model

/* tb/pci_bridge_internal_status_flags_test.sv */
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin failures++; \
   $display("unexpected %s: expected %h seen %h", nm, exp, got); end end
// ==========================================================================
// Bench for the bridge status flags
module pci_bridge_internal_status_flags_test;
   localparam int unsigned DC = 8;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic        hwrite = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2;
   logic        sl = 1'b1;
   logic [2:0]  sz = pbisf_pkg::HSIZE_WORD;
   wire logic   hready, hresp, irq, oe, pin, drop, expd, req, ld, cl, rs, rr, rdn;
   wire [31:0]  hrdata;
   wire pbisf_pkg::pbisf_evt_t evt;
   int unsigned failures = 0;
   int unsigned num_checks = 0;
   int unsigned cycles = 0;
   int unsigned pos [6] = '{pbisf_pkg::BIT_WR_BUS_ERR, pbisf_pkg::BIT_RD_BUS_ERR,
      pbisf_pkg::BIT_TA_ISSUED, pbisf_pkg::BIT_TA_RECEIVED, pbisf_pkg::BIT_MA_RECEIVED,
      pbisf_pkg::BIT_PARITY};

   pbisf_status_regs #(.DISCARD_CYCLES(DC)) u_pbisf_status_regs (.hclk(hclk),
      .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp),
      .hrdata(hrdata), .evt(evt), .system_error_request(req), .dr_data_loaded(ld),
      .dr_data_claimed(cl), .delayed_read_data_dropped(drop), .rty_access_start(rs),
      .rty_retry_seen(rr), .rty_access_done(rdn), .retry_limit_expired(expd),
      .system_error_out_n_o(pin), .system_error_out_n_oe(oe), .irq(irq));
   pbisf_engine_model u_pbisf_engine_model (.clk(hclk), .evt(evt), .serr_req(req),
      .loaded(ld), .claimed(cl), .rty_start(rs), .rty_retry(rr), .rty_done(rdn));

   // Clock
   initial begin
      forever #12.5 hclk = ~hclk;
   end

   // Hang guard
   always @(posedge hclk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         wrap_up();
      end
   end

   // Report and end the run
   task automatic wrap_up();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : wrap_up

   // One single transfer of size sz, a word unless sz is changed
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      hsel <= sl;
      haddr <= {24'h00_0000, a};
      htrans <= pbisf_pkg::HTRANS_NONSEQ;
      hwrite <= w;
      hsize <= sz;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      q = hrdata;
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0000_0000, q);
      `CHK($sformatf("reg %h", a), e, q)
   endtask : rd

   // Main sequence
   initial begin
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd(pbisf_pkg::OFS_STATUS, 32'h0000_0000);
      rd(pbisf_pkg::OFS_ENABLE, 32'h0000_0000);
      `CHK("hresp", pbisf_pkg::HRESP_OKAY, hresp)
      rd(8'h40, 32'h0000_0000);
      wr(pbisf_pkg::OFS_STATUS, 32'h0000_01FF);
      rd(pbisf_pkg::OFS_STATUS, 32'h0000_0000);
      // Transfers that must be ignored: not selected, not a word
      sl = 1'b0;
      wr(pbisf_pkg::OFS_ENABLE, 32'h0000_01FF);
      sl = 1'b1;
      sz = 3'h1;
      wr(pbisf_pkg::OFS_ENABLE, 32'h0000_01FF);
      sz = pbisf_pkg::HSIZE_WORD;
      rd(pbisf_pkg::OFS_ENABLE, 32'h0000_0000);
      for (int i = 0; i < 6; i++) begin
         u_pbisf_engine_model.pulse(i);
         rd(pbisf_pkg::OFS_STATUS, 32'h0000_0001 << pos[i]);
         wr(pbisf_pkg::OFS_CLEAR, 32'h0000_0001 << pos[i]);
      end
      wr(pbisf_pkg::OFS_ENABLE, 32'h0000_0100);
      u_pbisf_engine_model.pulse(5);
      repeat (3) @(posedge hclk);
      `CHK("irq", 1'b1, irq)
      wr(pbisf_pkg::OFS_ENABLE, 32'h0000_0080);
      repeat (2) @(posedge hclk);
      `CHK("irq", 1'b0, irq)
      u_pbisf_engine_model.serr(3);
      rd(pbisf_pkg::OFS_STATUS, 32'h0000_0180);
      `CHK("pin enable", 1'b0, oe)
      `CHK("irq", 1'b1, irq)
      wr(pbisf_pkg::OFS_CLEAR, 32'h0000_01FF);
      wr(pbisf_pkg::OFS_ENABLE, 32'h0000_0000);
      rd(pbisf_pkg::OFS_STATUS, 32'h0000_0000);
      u_pbisf_engine_model.pulse(6);
      repeat (DC - 4) @(posedge hclk);
      rd(pbisf_pkg::OFS_STATUS, 32'h0000_0000);
      repeat (8) @(posedge hclk);
      rd(pbisf_pkg::OFS_STATUS, 32'h0000_0008);
      wr(pbisf_pkg::OFS_CLEAR, 32'h0000_0008);
      u_pbisf_engine_model.pulse(6);
      repeat (3) @(posedge hclk);
      u_pbisf_engine_model.pulse(7);
      repeat (DC + 4) @(posedge hclk);
      rd(pbisf_pkg::OFS_STATUS, 32'h0000_0000);
      wr(pbisf_pkg::OFS_RTY_LIM, 32'h0000_0003);
      u_pbisf_engine_model.pulse(8);
      repeat (2) u_pbisf_engine_model.pulse(9);
      repeat (2) @(posedge hclk);
      rd(pbisf_pkg::OFS_STATUS, 32'h0000_0000);
      u_pbisf_engine_model.pulse(9);
      repeat (2) @(posedge hclk);
      rd(pbisf_pkg::OFS_STATUS, 32'h0000_0004);
      rd(pbisf_pkg::OFS_RTY_CNT, 32'h0000_0002);
      rd(pbisf_pkg::OFS_RTY_LIM, 32'h0000_0003);
      // Access that ends normally must not abandon on later retries
      wr(pbisf_pkg::OFS_CLEAR, 32'h0000_0004);
      u_pbisf_engine_model.pulse(8);
      rd(pbisf_pkg::OFS_LIVE, 32'h0000_0004);
      u_pbisf_engine_model.pulse(9);
      u_pbisf_engine_model.pulse(10);
      repeat (3) u_pbisf_engine_model.pulse(9);
      repeat (2) @(posedge hclk);
      rd(pbisf_pkg::OFS_STATUS, 32'h0000_0000);
      rd(pbisf_pkg::OFS_LIVE, 32'h0000_0000);
      wrap_up();
   end
endmodule : pci_bridge_internal_status_flags_test
